// *** hw/acs_sequencer.v ***
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
// What this block does
// - done flag in low register bit 5
// - busy flag bit 4, set start, clear end/standby
// - reading upper result clears done flag
// - low register bits 3..0 unspecified
// - mode 01 start bit runs one conversion
// - completion stores result, sets done, interrupts
// - start bit self-clears on the edge the conversion begins
// - mode 11 converts back to back
// - mode 00 aborts, result discarded
// - restart clears done, keeps old result
// - standby aborts and resets control registers
// - no automatic resume after standby
// - ladder disconnected during standby
// - ten-bit result split upper and low
// - result only after selected conversion time
// - time code selects 39 to 1248 cycles
// - ladder bit: during conversion or always
module acs_sequencer (
	input wire REF_CLK,
	input wire RESET,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [9:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	output wire WB_ERR_O,
	input wire STANDBY_ENTRY,
	input wire [9:0] CORE_RESULT,
	output reg [2:0] CORE_CHANNEL,
	output reg CORE_SAMPLE,
	output reg LADDER_CONNECT,
	output reg ANALOG_INPUT_DISABLE,
	output reg CONV_DONE_IRQ
);
	////////////////////////////////////////////////////////////////
	// bus access
	wire req;
	wire [7:0] idx;
	wire wr;
	wire rd;
	wire lane0;
	reg [7:0] ctrl_one_r;
	reg [7:0] ctrl_two_r;
	reg [9:0] result_r;
	reg done_r;
	reg standby_r;
	wire busy;
	wire conv_done;
	wire start_now;
	wire abort_now;
	wire [1:0] op_sel;

	acs_bus u_bus (
		.clk(REF_CLK),
		.rst(RESET),
		.cyc(WB_CYC_I),
		.stb(WB_STB_I),
		.ack(WB_ACK_O),
		.req(req)
	);

	assign idx = WB_ADR_I[9:2];
	assign lane0 = WB_SEL_I[0];
	// writes and read side effects land on the ack edge
	assign wr = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && lane0;
	assign rd = WB_ACK_O && WB_CYC_I && WB_STB_I && !WB_WE_I;
	assign WB_ERR_O = 1'b0;
	assign op_sel = ctrl_one_r[`ACS_C1_OPSEL_HI:`ACS_C1_OPSEL_LO];

	////////////////////////////////////////////////////////////////
	// standby request and control registers
	always @(posedge REF_CLK) begin
		if (RESET)
			standby_r <= 1'b0;
		else if (wr && idx == `ACS_IDX_STANDBY)
			standby_r <= WB_DAT_I[0];
		else
			standby_r <= standby_r;
	end

	wire in_standby;
	assign in_standby = standby_r || STANDBY_ENTRY;

	always @(posedge REF_CLK) begin
		if (RESET || in_standby) begin
			ctrl_one_r <= `ACS_C1_RESET;
			ctrl_two_r <= `ACS_C2_RESET;
		end else begin
			if (wr && idx == `ACS_IDX_CTRL_ONE)
				ctrl_one_r <= WB_DAT_I[7:0];
			else if (start_now)
				ctrl_one_r[`ACS_C1_START] <= 1'b0;
			if (wr && idx == `ACS_IDX_CTRL_TWO)
				ctrl_two_r <= WB_DAT_I[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// conversion control
	// a start bit with mode 00 or 10 stays set and starts nothing until the mode is 01 or 11
	assign start_now = !in_standby && ctrl_one_r[`ACS_C1_START] && !busy &&
		(op_sel == `ACS_OP_SINGLE || op_sel == `ACS_OP_REPEAT);
	wire repeat_next;
	reg repeat_arm_r;
	assign repeat_next = conv_done && repeat_arm_r && op_sel == `ACS_OP_REPEAT;
	assign abort_now = in_standby || (busy && op_sel == `ACS_OP_OFF);

	always @(posedge REF_CLK) begin
		if (RESET || abort_now)
			repeat_arm_r <= 1'b0;
		else if (start_now)
			repeat_arm_r <= (op_sel == `ACS_OP_REPEAT);
		else
			repeat_arm_r <= repeat_arm_r;
	end

	acs_timer u_timer (
		.clk(REF_CLK),
		.rst(RESET),
		.start(start_now || repeat_next),
		.abort(abort_now),
		.time_code(ctrl_two_r[`ACS_C2_TIME_HI:`ACS_C2_TIME_LO]),
		.running(busy),
		.done(conv_done)
	);

	////////////////////////////////////////////////////////////////
	// result and flags
	always @(posedge REF_CLK) begin
		if (RESET) begin
			result_r <= `ACS_RES_RESET;
			done_r <= 1'b0;
			CONV_DONE_IRQ <= 1'b0;
		end else begin
			CONV_DONE_IRQ <= conv_done && !abort_now;
			if (conv_done && !abort_now) begin
				result_r <= CORE_RESULT;
				done_r <= 1'b1;
			end else if (start_now || in_standby ||
				(rd && idx == `ACS_IDX_RES_UPPER)) begin
				done_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// analog side
	always @(posedge REF_CLK) begin
		if (RESET) begin
			CORE_CHANNEL <= 3'h0;
			CORE_SAMPLE <= 1'b0;
			LADDER_CONNECT <= 1'b0;
			ANALOG_INPUT_DISABLE <= 1'b0;
		end else begin
			CORE_CHANNEL <= ctrl_one_r[`ACS_C1_CH_HI - 1:`ACS_C1_CH_LO];
			CORE_SAMPLE <= start_now || repeat_next;
			LADDER_CONNECT <= !in_standby &&
				(ctrl_two_r[`ACS_C2_LADDER] || busy);
			ANALOG_INPUT_DISABLE <= ctrl_one_r[`ACS_C1_AIN_DIS];
		end
	end

	////////////////////////////////////////////////////////////////
	// read data
	always @(posedge REF_CLK) begin
		if (RESET) begin
			WB_DAT_O <= 32'h00000000;
		end else if (req) begin
			case (idx)
				`ACS_IDX_CTRL_ONE: WB_DAT_O <= {24'h000000, ctrl_one_r};
				`ACS_IDX_CTRL_TWO: WB_DAT_O <= {24'h000000, ctrl_two_r};
				`ACS_IDX_RES_UPPER: WB_DAT_O <= {24'h000000, result_r[9:2]};
				// low nibble reads zero here; callers must ignore it
				`ACS_IDX_RES_LOW: WB_DAT_O <= {24'h000000, result_r[1:0], done_r,
					busy, 4'h0};
				`ACS_IDX_STANDBY: WB_DAT_O <= {31'h00000000, standby_r};
				default: WB_DAT_O <= 32'h00000000;
			endcase
		end else begin
			WB_DAT_O <= WB_DAT_O;
		end
	end
endmodule // acs_sequencer
`default_nettype wire

// *** hw/acs_consts.vh ***
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// register word addresses (byte address = index * 4)
`define ACS_IDX_CTRL_ONE 8'h0E
`define ACS_IDX_CTRL_TWO 8'h0F
`define ACS_IDX_RES_UPPER 8'h20
`define ACS_IDX_RES_LOW 8'h21
`define ACS_IDX_STANDBY 8'h30
// control one fields
`define ACS_C1_START 7
`define ACS_C1_OPSEL_HI 6
`define ACS_C1_OPSEL_LO 5
`define ACS_C1_AIN_DIS 4
`define ACS_C1_CH_HI 3
`define ACS_C1_CH_LO 0
// control two fields
`define ACS_C2_LADDER 5
`define ACS_C2_TIME_HI 3
`define ACS_C2_TIME_LO 1
// result low fields
`define ACS_RL_DONE 5
`define ACS_RL_BUSY 4
// reset values
`define ACS_C1_RESET 8'h00
`define ACS_C2_RESET 8'h00
`define ACS_RES_RESET 10'h000
// operating modes
`define ACS_OP_OFF 2'h0
`define ACS_OP_SINGLE 2'h1
`define ACS_OP_REPEAT 2'h3
// conversion lengths in clock cycles
`define ACS_T_CODE0 11'd39
`define ACS_T_CODE2 11'd78
`define ACS_T_CODE3 11'd156
`define ACS_T_CODE4 11'd312
`define ACS_T_CODE5 11'd624
`define ACS_T_CODE6 11'd1248
`endif

// *** hw/acs_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
module acs_timer (
	input wire clk,
	input wire rst,
	input wire start,
	input wire abort,
	input wire [2:0] time_code,
	output reg running,
	output reg done
);
	reg [10:0] cnt_r;
	reg [10:0] len;
	always @* begin
		case (time_code)
			3'h0: len = `ACS_T_CODE0;
			3'h2: len = `ACS_T_CODE2;
			3'h3: len = `ACS_T_CODE3;
			3'h4: len = `ACS_T_CODE4;
			3'h5: len = `ACS_T_CODE5;
			3'h6: len = `ACS_T_CODE6;
			default: len = `ACS_T_CODE0;
		endcase
	end
	always @(posedge clk) begin
		if (rst || abort) begin
			running <= 1'b0;
			done <= 1'b0;
			cnt_r <= 11'h000;
		end else if (start) begin
			running <= 1'b1;
			done <= 1'b0;
			cnt_r <= len - 11'd1;
		end else if (running) begin
			if (cnt_r == 11'h000) begin
				running <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 11'd1;
				done <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule // acs_timer
`default_nettype wire

// *** hw/acs_bus.v ***
`timescale 1ns/1ps
`default_nettype none
module acs_bus (
	input wire clk,
	input wire rst,
	input wire cyc,
	input wire stb,
	output reg ack,
	output wire req
);
	// one-wait-state slave: ack one cycle after strobe, dropped next cycle
	assign req = cyc && stb && !ack;
	always @(posedge clk) begin
		if (rst)
			ack <= 1'b0;
		else
			ack <= req;
	end
endmodule // acs_bus
`default_nettype wire

// *** bench/acs_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
	input wire clk,
	input wire sample,
	input wire [2:0] channel,
	output logic [9:0] result = 10'h000
);
	// level depends on the channel held at sample
	always @(posedge clk) if (sample) result <= {channel, 7'h5A} ^ 10'h2C3;
endmodule // acs_core_model
`default_nettype wire

// *** bench/acs_seq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_seq_sva (
	input wire REF_CLK,
	input wire RESET,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_ACK_O,
	input wire WB_ERR_O,
	input wire STANDBY_ENTRY,
	input wire CORE_SAMPLE,
	input wire LADDER_CONNECT,
	input wire CONV_DONE_IRQ
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	ack_taken_a:
	assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
	ack_pulse_a:
	assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
	err_low_a:
	assert property (!WB_ERR_O) else $error("err set");
	irq_pulse_a:
	assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ) else $error("irq long");
	sample_gap_a:
	assert property (CORE_SAMPLE |=> !CORE_SAMPLE [*4]) else $error("start too soon");
	irq_apart_a:
	assert property (CONV_DONE_IRQ |-> !$past(CORE_SAMPLE)) else $error("irq right after start");
	stby_ladder_a:
	assert property (STANDBY_ENTRY [*2] |-> !LADDER_CONNECT) else $error("ladder on");
	stby_idle_a:
	assert property (STANDBY_ENTRY [*2] |-> !CORE_SAMPLE && !CONV_DONE_IRQ) else $error("busy");
endmodule // acs_seq_sva
bind acs_sequencer acs_seq_sva i_acs_seq_sva (.REF_CLK, .RESET, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .WB_ERR_O, .STANDBY_ENTRY, .CORE_SAMPLE, .LADDER_CONNECT, .CONV_DONE_IRQ);
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 0, rst = 1, cyc = 0, we = 0, stby = 0;
	logic [9:0] adr = 10'h000, r;
	logic [31:0] dat = 32'h0, q;
	wire [31:0] rd_q;
	wire ack, irq, smp, lad, ain;
	wire [2:0] ch;
	wire [9:0] res;
	int err_total = 0, num_checks = 0, cn = 0, ti = 0, ni = 0, t0, ts, n0;
	int nt [7] = '{39, 39, 78, 156, 312, 624, 1248};
	acs_sequencer i_acs_sequencer (.REF_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(rd_q),
		.WB_ACK_O(ack), .WB_ERR_O(), .STANDBY_ENTRY(stby), .CORE_RESULT(res),
		.CORE_CHANNEL(ch), .CORE_SAMPLE(smp), .LADDER_CONNECT(lad),
		.ANALOG_INPUT_DISABLE(ain), .CONV_DONE_IRQ(irq));
	acs_core_model i_acs_core_model (.clk(clk), .sample(smp), .channel(ch), .result(res));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cn <= cn + 1;
		if (irq === 1'b1) begin
			ni <= ni + 1;
			ti <= cn;
		end
		if (cn > 9000) begin
			err_total++;
			final_report;
		end
	end
	task automatic acc(input logic [7:0] i, input logic w, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rd_q;
		t0 = cn;
		cyc <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] i, e, m);
		acc(i, 1'b0, 8'h00);
		chk(q & m, e & m);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h0E, 8'h00, 8'hFF);
		rd(8'h0F, 8'h00, 8'hFF);
		rd(8'h21, 8'h00, 8'hF0);
		rd(8'h01, 8'h00, 8'hFF);
		$display("reset test done");
		for (int k = 0; k < 7; k++) begin
			r = {k[2:0], 7'h5A} ^ 10'h2C3;
			acc(8'h0F, 1'b1, {4'h1, k[2:0], 1'b0});
			n0 = ni;
			acc(8'h0E, 1'b1, {5'h14, k[2:0]});
			ts = t0;
			rd(8'h0E, {5'h04, k[2:0]}, 8'hFF);
			rd(8'h21, 8'h10, 8'h30);
			while (ni == n0) @(posedge clk);
			chk(ti - ts, nt[k] + 3);
			rd(8'h21, {r[1:0], 6'h20}, 8'hF0);
			rd(8'h20, r[9:2], 8'hFF);
			rd(8'h21, 8'h00, 8'h30);
		end
		$display("single test done");
		r = {3'h5, 7'h5A} ^ 10'h2C3;
		acc(8'h0F, 1'b1, 8'h30);
		n0 = ni;
		acc(8'h0E, 1'b1, 8'hE5);
		chk(lad, 1'b1);
		while (ni == n0) @(posedge clk);
		ts = ti;
		while (ni == n0 + 1) @(posedge clk);
		// one idle cycle between back-to-back conversions
		chk(ti - ts, 40);
		acc(8'h0E, 1'b1, 8'h15);
		n0 = ni;
		repeat (60) @(posedge clk);
		chk(ni, n0);
		chk(ain, 1'b1);
		rd(8'h21, {r[1:0], 6'h20}, 8'hF0);
		acc(8'h0E, 1'b1, 8'hA5);
		rd(8'h21, {r[1:0], 6'h10}, 8'hF0);
		$display("repeat test done");
		stby <= 1'b1;
		repeat (5) @(posedge clk);
		chk(lad, 1'b0);
		stby <= 1'b0;
		rd(8'h0E, 8'h00, 8'hFF);
		rd(8'h0F, 8'h00, 8'hFF);
		rd(8'h21, 8'h00, 8'h30);
		n0 = ni;
		repeat (60) @(posedge clk);
		chk(ni, n0);
		chk(lad, 1'b0);
		$display("standby test done");
		final_report;
	end
endmodule // testbench
`default_nettype wire
